//--- can_mailbox_config_and_timer_tb.sv
// self-checking bench for the timer, captures and mailbox decode
// assumes apb answers in the cycle after setup, one clock at 20 MHz
`timescale 1ns/1ps
module can_mailbox_config_and_timer_tb;
   import cmt_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic sof_pulse, eof_pulse, tx_pending_set, tx_acknowledge_set;
   logic timer_in_message = 1'b0;
   logic [3:0] msg_mailbox = 4'h0;
   logic [7:0] cycle_count = 8'h00;
   logic [7:0] message_byte_one = 8'h00;
   logic [11:0] msg_addr;
   logic [15:0] msg_word0, msg_word1;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [31:0] rnd = 32'h220EE300;
   logic [3:0] mb;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   localparam logic [7:0] caps_exp [8] = '{8'h13, 8'h6B, 8'h4C, 8'h80, 8'h4E, 8'h46, 8'h80, 8'h00};
   always #25 pclk = ~pclk;
   cmt_timer cmt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sof_pulse(sof_pulse), .eof_pulse(eof_pulse),
      .tx_pending_set(tx_pending_set), .tx_acknowledge_set(tx_acknowledge_set),
      .timer_in_message(timer_in_message), .msg_mailbox(msg_mailbox), .cycle_count(cycle_count),
      .message_byte_one(message_byte_one), .msg_addr(msg_addr), .msg_word0(msg_word0),
      .msg_word1(msg_word1), .irq(irq));
   cmt_can_node cmt_can_node_inst (.pclk(pclk), .sof_pulse(sof_pulse), .eof_pulse(eof_pulse),
      .tx_pending_set(tx_pending_set), .tx_acknowledge_set(tx_acknowledge_set));
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic conclude();
      if (exp_q.size() != 0)
         bad_count++;
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] ex, input logic [31:0] s);
      checks++;
      if (s !== ex)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, ex, s);
      end
   endtask
   // note: [33] read, [32] error, [31:0] read data
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] ex);
      exp_q.push_back(ex);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0, d}, 34'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] ex);
      apb(1'b0, a, 32'h0, {2'b10, 16'h0, ex});
   endtask
   task automatic irq_is(input logic ex);
      repeat (2) @(posedge pclk);
      cmp("irq", {31'h0, ex}, {31'h0, irq});
   endtask
   // ************************************************************
   // monitor and timeout
   // ************************************************************
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         conclude();
      end
      if (pready === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
         if (e[33])
            cmp("prdata", e[31:0], prdata);
      end
   end
   // ************************************************************
   // scenarios
   // ************************************************************
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(cmt_off_count, 16'h0000);
      rd(cmt_off_control, 16'h0000);
      wr(cmt_off_count, 16'h1234);
      repeat (5) @(posedge pclk);
      rd(cmt_off_count, 16'h1234);
      // unmapped space from c0h up, random direction
      rnd = xs(rnd);
      apb(rnd[20], {2'b11, rnd[5:0]}, rnd, {~rnd[20], 1'b1, 32'h0});
      apb(~rnd[20], {2'b11, rnd[13:8]}, ~rnd, {rnd[20], 1'b1, 32'h0});
      rd(cmt_off_count, 16'h1234);
      rd(cmt_off_clear, 16'h0000);
      // run then stop: counts on to the wrap
      wr(cmt_off_compare0, 16'h0010);
      wr(cmt_off_count, 16'hFFFA);
      wr(cmt_off_control, 16'h8000);
      wr(cmt_off_control, 16'h0000);
      repeat (20) @(posedge pclk);
      rd(cmt_off_count, 16'h0000);
      rd(cmt_off_status, 16'h0001);
      wr(cmt_off_clear, 16'h000F);
      // compare match reload, then stop
      wr(cmt_off_offset, 16'h0100);
      wr(cmt_off_count, 16'h0000);
      wr(cmt_off_control, 16'h8800);
      wr(cmt_off_control, 16'h0800);
      repeat (30) @(posedge pclk);
      rd(cmt_off_count, 16'h0100);
      rd(cmt_off_status, 16'h0002);
      irq_is(1'b0);
      wr(cmt_off_irq_en, 16'h0002);
      irq_is(1'b1);
      wr(cmt_off_irq_en, 16'h0000);
      irq_is(1'b0);
      wr(cmt_off_irq_en, 16'h0002);
      wr(cmt_off_clear, 16'h0002);
      irq_is(1'b0);
      rd(cmt_off_status, 16'h0000);
      // capture registers
      wr(cmt_off_control, 16'h4000);
      wr(cmt_off_count, 16'h1234);
      cmt_can_node_inst.pulse(0);
      rd(cmt_off_capture0, 16'h1234);
      wr(cmt_off_control, 16'h0000);
      wr(cmt_off_count, 16'h5555);
      cmt_can_node_inst.pulse(0);
      rd(cmt_off_capture0, 16'h1234);
      rd(cmt_off_capture1, 16'h5555);
      wr(cmt_off_control, 16'h2000);
      wr(cmt_off_count, 16'h0A0A);
      cmt_can_node_inst.pulse(0);
      rd(cmt_off_capture1, 16'h5555);
      cmt_can_node_inst.pulse(1);
      rd(cmt_off_capture1, 16'h0A0A);
      wr(cmt_off_control, 16'h1000);
      wr(cmt_off_count, 16'h0B0B);
      cmt_can_node_inst.pulse(2);
      rd(cmt_off_capture1, 16'h0A0A);
      cmt_can_node_inst.pulse(3);
      rd(cmt_off_capture1, 16'h0B0B);
      wr(cmt_off_control, 16'h0000);
      wr(cmt_off_count, 16'h0C0C);
      cmt_can_node_inst.pulse(2);
      rd(cmt_off_capture1, 16'h0C0C);
      rd(cmt_off_status, 16'h000C);
      // mailbox codes on a random non-zero mailbox, then codes 000 and 010 on mailbox zero
      rnd = xs(rnd);
      mb = 4'(rnd[7:0] % 15 + 1);
      for (int c = 0; c < 8; c++)
      begin
         wr(cmt_off_mb_config, {8'h0, mb, 1'b0, 3'(c)});
         rd(cmt_off_mb_config, {8'h0, mb, 1'b0, 3'(c)});
         rd(cmt_off_mb_caps, {8'h0, caps_exp[c]});
      end
      wr(cmt_off_mb_config, 16'h0000);
      rd(cmt_off_mb_caps, 16'h0080);
      wr(cmt_off_mb_config, 16'h0002);
      rd(cmt_off_mb_caps, 16'h004C);
      // timer value placed in message data
      wr(cmt_off_count, 16'h1A2B);
      rnd = xs(rnd);
      timer_in_message <= 1'b1;
      msg_mailbox <= rnd[3:0];
      cycle_count <= rnd[11:4];
      message_byte_one <= rnd[19:12];
      repeat (3) @(posedge pclk);
      cmp("msg_addr", {20'h0, 12'h108 + {3'h0, rnd[3:0], 5'h0}}, {20'h0, msg_addr});
      cmp("msg_word0", {16'h0, rnd[11:4], rnd[19:12]}, {16'h0, msg_word0});
      cmp("msg_word1", 32'h2B1A, {16'h0, msg_word1});
      timer_in_message <= 1'b0;
      message_byte_one <= ~rnd[19:12];
      repeat (3) @(posedge pclk);
      cmp("msg_word0", {16'h0, rnd[11:4], rnd[19:12]}, {16'h0, msg_word0});
      // reset in mid-run
      presetn <= 1'b0;
      @(posedge pclk);
      cmp("msg_addr", 32'h0, {20'h0, msg_addr});
      presetn <= 1'b1;
      @(posedge pclk);
      rd(cmt_off_count, 16'h0000);
      rd(cmt_off_mb_caps, 16'h0000);
      conclude();
   end
endmodule

//--- cmt_can_node.sv
// other nodes on the can bus, seen as frame event strobes
// assumes pclk from the bench; each strobe is one cycle wide
`timescale 1ns/1ps
module cmt_can_node
(
   // clock
   input wire logic pclk,
   // frame events
   output logic sof_pulse,
   output logic eof_pulse,
   output logic tx_pending_set,
   output logic tx_acknowledge_set
);
   initial
   begin
      sof_pulse = 1'b0;
      eof_pulse = 1'b0;
      tx_pending_set = 1'b0;
      tx_acknowledge_set = 1'b0;
   end
   // 0 sof, 1 eof, 2 tx pending, 3 tx acknowledge
   task automatic pulse(input int k);
      @(posedge pclk);
      sof_pulse <= (k == 0);
      eof_pulse <= (k == 1);
      tx_pending_set <= (k == 2);
      tx_acknowledge_set <= (k == 3);
      @(posedge pclk);
      sof_pulse <= 1'b0;
      eof_pulse <= 1'b0;
      tx_pending_set <= 1'b0;
      tx_acknowledge_set <= 1'b0;
      @(posedge pclk);
   endtask
endmodule

//--- cmt_mb_decode.sv
// decodes one mailbox configuration code into frame permissions
// assumes a code value from the register file; outputs registered
`timescale 1ns/1ps
module cmt_mb_decode
   import cmt_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // code in
   input wire logic [2:0] mailbox_config_code,
   input wire logic is_mailbox0,
   // permissions: tx data, tx remote, rx data, rx remote, time trig, auto tx, mask, illegal
   output logic [7:0] caps
);
   logic [7:0] next_caps;
   always_comb
   begin
      next_caps = 8'h00;
      case (cmt_mbc_e'(mailbox_config_code))
         cmt_mb_tx_all: next_caps = 8'b0001_0011;
         cmt_mb_tx_rxrem: next_caps = 8'b0110_1011;
         cmt_mb_rx_all: next_caps = 8'b0100_1100;
         cmt_mb_txrem_rxall: next_caps = 8'b0100_1110;
         cmt_mb_txrem_rxdat: next_caps = 8'b0100_0110;
         cmt_mb_off: next_caps = 8'h00;
         default: next_caps = 8'h80;
      endcase
      // mailbox zero never transmits; a transmit code is flagged illegal
      if (is_mailbox0 && (next_caps[1:0] != 2'b00))
      begin
         next_caps = 8'h80;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         caps <= 8'h00;
      else
         caps <= next_caps;
   end
   mb0_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_mailbox0 |=> caps[1:0] == 2'b00) else $error("mailbox zero allowed to transmit");
   rx_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      mailbox_config_code == 3'b010 |=> caps[3:0] == 4'b1100) else $error("code 010 bad");
endmodule

//--- cmt_pkg.sv
// constants, register map and field layout of the mailbox config and timer block
// assumes an apb slave with 32-bit data; registers sit in the low bits of each word
// Function
// - code 000: transmit data and remote, receive none, time trigger allowed
// - code 001: transmit both, receive remote only, auto transmit and mask usable
// - code 010: receive both, transmit none; only receive code for mailbox zero
// - 100 tx remote rx both; 101 tx remote rx data; 011,110 barred; 111 off
// - timer in message: cycle count upper byte at 108h plus 20h per mailbox, next word swapped timer
// - timer count is 16 bits, read and write, reset to zero
// - timer run bit 15 set makes counter free run, clear stops it
// - compare0 clear set and count equals compare0 loads local offset
// - after run cleared counter goes on until next overflow or compare match
// - bit 14 set: capture 0 latches timer at every start of frame
// - bit 14 clear: capture 0 holds its value
// - rx stamp select picks capture 1 at start (0) or end (1) of frame
// - tx stamp select stamps at tx pending (0) or tx acknowledge (1)
package cmt_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] cmt_off_count = 8'h00;
   localparam logic [7:0] cmt_off_control = 8'h04;
   localparam logic [7:0] cmt_off_compare0 = 8'h08;
   localparam logic [7:0] cmt_off_offset = 8'h0C;
   localparam logic [7:0] cmt_off_capture0 = 8'h10;
   localparam logic [7:0] cmt_off_capture1 = 8'h14;
   localparam logic [7:0] cmt_off_status = 8'h18;
   localparam logic [7:0] cmt_off_clear = 8'h1C;
   localparam logic [7:0] cmt_off_irq_en = 8'h20;
   localparam logic [7:0] cmt_off_mb_config = 8'h24;
   localparam logic [7:0] cmt_off_mb_caps = 8'h28;
   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam int cmt_bit_run = 15;
   localparam int cmt_bit_cap0 = 14;
   localparam int cmt_bit_rx_sel = 13;
   localparam int cmt_bit_tx_sel = 12;
   localparam int cmt_bit_cmp0_clr = 11;
   localparam logic [15:0] cmt_rst_count = 16'h0000;
   localparam logic [15:0] cmt_rst_control = 16'h0000;
   localparam logic [15:0] cmt_rst_word = 16'h0000;
   localparam logic [2:0] cmt_rst_mb_config = 3'h7;
   localparam int cmt_n_mailbox = 16;
   // status bits: overflow, compare0, capture0, capture1
   localparam int cmt_st_ovf = 0;
   localparam int cmt_st_cmp = 1;
   localparam int cmt_st_cap0 = 2;
   localparam int cmt_st_cap1 = 3;
   localparam int cmt_n_events = 4;
   // timer in message data placement
   localparam logic [11:0] cmt_msg_base = 12'h108;
   localparam logic [11:0] cmt_msg_stride = 12'h020;
   // ************************************************************
   // mailbox configuration codes
   // ************************************************************
   typedef enum logic [2:0] {
      cmt_mb_tx_all = 3'b000,
      cmt_mb_tx_rxrem = 3'b001,
      cmt_mb_rx_all = 3'b010,
      cmt_mb_bad3 = 3'b011,
      cmt_mb_txrem_rxall = 3'b100,
      cmt_mb_txrem_rxdat = 3'b101,
      cmt_mb_bad6 = 3'b110,
      cmt_mb_off = 3'b111
   } cmt_mbc_e;
   // timer run state
   typedef enum logic [1:0] {
      cmt_tm_stop = 2'b00,
      cmt_tm_run = 2'b01,
      cmt_tm_drain = 2'b10
   } cmt_tm_e;
endpackage

//--- cmt_timer.sv
// timer, captures, mailbox config table and apb register file
// assumes a standard apb master; sof/eof/tx strobes are one-cycle pulses on pclk
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module cmt_timer
   import cmt_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // can frame events
   input wire logic sof_pulse,
   input wire logic eof_pulse,
   input wire logic tx_pending_set,
   input wire logic tx_acknowledge_set,
   // mailbox data with timer in message
   input wire logic timer_in_message,
   input wire logic [3:0] msg_mailbox,
   input wire logic [7:0] cycle_count,
   input wire logic [7:0] message_byte_one,
   output logic [11:0] msg_addr,
   output logic [15:0] msg_word0,
   output logic [15:0] msg_word1,
   // interrupt
   output logic irq
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [15:0] timer_count;
   logic [15:0] timer_control;
   logic [15:0] compare_match0;
   logic [15:0] local_offset;
   logic [15:0] capture_reg0;
   logic [15:0] capture_reg1;
   logic [cmt_n_events-1:0] status;
   logic [cmt_n_events-1:0] irq_en;
   logic [2:0] mb_cfg [cmt_n_mailbox];
   logic [3:0] cfg_sel;
   logic [7:0] caps;
   cmt_tm_e tm_state;
   // ************************************************************
   // decode
   // ************************************************************
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_count = paddr == cmt_off_count;
   wire hit_control = paddr == cmt_off_control;
   wire hit_cmp = paddr == cmt_off_compare0;
   wire hit_off = paddr == cmt_off_offset;
   wire hit_cap0 = paddr == cmt_off_capture0;
   wire hit_cap1 = paddr == cmt_off_capture1;
   wire hit_status = paddr == cmt_off_status;
   wire hit_clear = paddr == cmt_off_clear;
   wire hit_en = paddr == cmt_off_irq_en;
   wire hit_mbc = paddr == cmt_off_mb_config;
   wire hit_caps = paddr == cmt_off_mb_caps;
   wire mapped = hit_count | hit_control | hit_cmp | hit_off | hit_cap0 | hit_cap1
      | hit_status | hit_clear | hit_en | hit_mbc | hit_caps;
   wire run_bit = timer_control[cmt_bit_run];
   wire cap0_en = timer_control[cmt_bit_cap0];
   wire rx_sel = timer_control[cmt_bit_rx_sel];
   wire tx_sel = timer_control[cmt_bit_tx_sel];
   wire cmp_clr = timer_control[cmt_bit_cmp0_clr];
   // ************************************************************
   // timer
   // ************************************************************
   wire ticking = tm_state != cmt_tm_stop;
   wire at_match = ticking && (timer_count == compare_match0);
   wire wrap = ticking && !(cmp_clr && at_match) && (timer_count == 16'hFFFF);
   wire reload = cmp_clr && at_match;
   wire stop_event = wrap || at_match;
   wire [15:0] next_count = reload ? local_offset
      : ticking ? timer_count + 16'h0001 : timer_count;
   cmt_tm_e next_tm;
   always_comb
   begin
      next_tm = tm_state;
      case (tm_state)
         cmt_tm_stop: if (run_bit) next_tm = cmt_tm_run;
         cmt_tm_run: if (!run_bit) next_tm = stop_event ? cmt_tm_stop : cmt_tm_drain;
         cmt_tm_drain:
         begin
            if (run_bit)
               next_tm = cmt_tm_run;
            else if (stop_event)
               next_tm = cmt_tm_stop;
         end
         default: next_tm = cmt_tm_stop;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tm_state <= cmt_tm_stop;
      else
         tm_state <= next_tm;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_count <= cmt_rst_count;
      else if (wr && hit_count)
         timer_count <= pwdata[15:0];
      else
         timer_count <= next_count;
   end
   // ************************************************************
   // captures
   // ************************************************************
   wire cap0_take = sof_pulse && cap0_en;
   wire rx_take = rx_sel ? eof_pulse : sof_pulse;
   wire tx_take = tx_sel ? tx_acknowledge_set : tx_pending_set;
   wire cap1_take = rx_take || tx_take;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         capture_reg0 <= cmt_rst_word;
      else if (cap0_take)
         capture_reg0 <= timer_count;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         capture_reg1 <= cmt_rst_word;
      else if (cap1_take)
         capture_reg1 <= timer_count;
   end
   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_control <= cmt_rst_control;
         compare_match0 <= cmt_rst_word;
         local_offset <= cmt_rst_word;
         irq_en <= '0;
         cfg_sel <= 4'h0;
      end
      else if (wr)
      begin
         if (hit_control)
            timer_control <= pwdata[15:0];
         if (hit_cmp)
            compare_match0 <= pwdata[15:0];
         if (hit_off)
            local_offset <= pwdata[15:0];
         if (hit_en)
            irq_en <= pwdata[cmt_n_events-1:0];
         if (hit_mbc)
            cfg_sel <= pwdata[7:4];
      end
   end
   // mailbox config table, one entry per mailbox
   genvar gi;
   generate
      for (gi = 0; gi < cmt_n_mailbox; gi++)
      begin : g_mb
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               mb_cfg[gi] <= cmt_rst_mb_config;
            else if (wr && hit_mbc && pwdata[7:4] == 4'(gi))
               mb_cfg[gi] <= pwdata[2:0];
         end
      end
   endgenerate
   cmt_mb_decode u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .mailbox_config_code(mb_cfg[cfg_sel]),
      .is_mailbox0(cfg_sel == 4'h0),
      .caps(caps)
   );
   // ************************************************************
   // interrupt status, set wins over clear
   // ************************************************************
   wire [cmt_n_events-1:0] ev = {cap1_take, cap0_take, at_match, wrap};
   wire [cmt_n_events-1:0] clr = (wr && hit_clear) ? pwdata[cmt_n_events-1:0] : '0;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status <= '0;
         irq <= 1'b0;
      end
      else
      begin
         status <= (status & ~clr) | ev;
         irq <= |(((status & ~clr) | ev) & irq_en);
      end
   end
   // ************************************************************
   // timer in message layout
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         msg_addr <= 12'h000;
         msg_word0 <= 16'h0000;
         msg_word1 <= 16'h0000;
      end
      else if (timer_in_message)
      begin
         msg_addr <= cmt_msg_base + 12'(msg_mailbox) * cmt_msg_stride;
         msg_word0 <= {cycle_count, message_byte_one};
         msg_word1 <= {timer_count[7:0], timer_count[15:8]};
      end
   end
   // ************************************************************
   // apb read and answer
   // ************************************************************
   wire [31:0] rd_mux =
      hit_count ? {16'h0000, timer_count}
      : hit_control ? {16'h0000, timer_control}
      : hit_cmp ? {16'h0000, compare_match0}
      : hit_off ? {16'h0000, local_offset}
      : hit_cap0 ? {16'h0000, capture_reg0}
      : hit_cap1 ? {16'h0000, capture_reg1}
      : hit_status ? {28'h0000000, status}
      : hit_en ? {28'h0000000, irq_en}
      : hit_mbc ? {24'h000000, cfg_sel, 1'b0, mb_cfg[cfg_sel]}
      : hit_caps ? {24'h000000, caps}
      : 32'h00000000;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
      end
   end
   // ************************************************************
   // checks
   // ************************************************************
   stopped_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tm_state == cmt_tm_stop && !(wr && hit_count)) |=> timer_count == $past(timer_count))
      else $error("stopped timer moved");
   reload_val_a: assert property (@(posedge pclk) disable iff (!presetn)
      (reload && !(wr && hit_count)) |=> timer_count == $past(local_offset))
      else $error("compare reload wrong");
   drain_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tm_state == cmt_tm_drain && stop_event && !run_bit) |=> tm_state == cmt_tm_stop)
      else $error("drain did not stop");
   run_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tm_state == cmt_tm_run && !run_bit && !stop_event) |=> tm_state == cmt_tm_drain)
      else $error("timer stopped early");
   cap0_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sof_pulse && cap0_en) |=> capture_reg0 == $past(timer_count))
      else $error("capture0 missed");
   cap0_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cap0_en |=> capture_reg0 == $past(capture_reg0)) else $error("capture0 moved");
   wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wrap && !(wr && hit_count)) |=> timer_count == 16'h0000 && status[cmt_st_ovf])
      else $error("wrap wrong");
   rx_stamp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_sel && eof_pulse) |=> capture_reg1 == $past(timer_count))
      else $error("eof stamp missed");
   tx_stamp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_sel && tx_acknowledge_set) |=> capture_reg1 == $past(timer_count))
      else $error("ack stamp missed");
   msg_swap_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_in_message |=> msg_word1 == {$past(timer_count[7:0]), $past(timer_count[15:8])})
      else $error("timer bytes not swapped");
endmodule
